// File: logic/seew_top.sv
/*
  Top of the two-wire EEPROM write slave: start and stop detection on the
  core clock, page buffer, programming sequencer and busy timer.
  Assumes a byte-wide memory array outside that takes MEM_WE_O writes, and
  SCL no faster than one quarter of CORE_CLK_I with SDA settled one core
  cycle around each SCL edge, and at least eight core cycles from a stop
  to the SCL fall of the next start.
*/
`timescale 1ns/1ps

module seew_top #(
  parameter logic [3:0] DEVICE_TYPE_CODE = 4'h5, // Arbitrary value
  parameter bit IS_16K = 1'b0,
  parameter int unsigned WRITE_CYCLES = seew_pkg::WRITE_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic WP_I,
  input wire logic ADDRESS_STRAP_PIN_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic BUSY_O,
  output logic MEM_WE_O,
  output logic [10:0] MEM_ADDR_O,
  output logic [7:0] MEM_DATA_O
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic wp_m;
    logic wp_s;
    logic tog_m;
    logic tog_s;
    logic tog_d;
    logic bus_free;
    seew_pkg::seew_core_e state;
    logic [2:0] block;
    logic [7:0] base;
    logic [3:0] ptr;
    logic [15:0][7:0] page_buf;
    logic [15:0] valid;
    logic [4:0] idx;
    logic [seew_pkg::BUSY_CNT_W-1:0] cnt;
    logic busy;
    logic mem_we;
    logic [10:0] mem_addr;
    logic [7:0] mem_data;
  } seew_core_s;

  seew_core_s c_reg;
  seew_core_s c_next;
  logic link_oe;
  logic ev_toggle;
  logic [1:0] ev_kind;
  logic [7:0] ev_data;
  logic start_cond;
  logic stop_cond;
  logic ev_new;
  logic [3:0] loc;

  // SDA moving while SCL stays high
  function automatic logic bus_cond(input logic scl_a, input logic scl_b, input logic sda_old,
                                    input logic sda_new);
    bus_cond = scl_a && scl_b && (sda_old != sda_new);
  endfunction : bus_cond

  seew_link #(
    .DEVICE_TYPE_CODE(DEVICE_TYPE_CODE),
    .IS_16K(IS_16K)
  ) u_link (
    .scl_clk_i(SCL_I),
    .reset_n_i(RESET_N_I),
    .sda_i(SDA_I),
    .strap_i(ADDRESS_STRAP_PIN_I),
    .busy_i(c_reg.busy),
    .bus_free_i(c_reg.bus_free),
    .sda_oe_o(link_oe),
    .ev_toggle_o(ev_toggle),
    .ev_kind_o(ev_kind),
    .ev_data_o(ev_data)
  );

  always_comb begin
    c_next = c_reg;
    c_next.scl_m = SCL_I;
    c_next.scl_s = c_reg.scl_m;
    c_next.scl_d = c_reg.scl_s;
    c_next.sda_m = SDA_I;
    c_next.sda_s = c_reg.sda_m;
    c_next.sda_d = c_reg.sda_s;
    c_next.wp_m = WP_I;
    c_next.wp_s = c_reg.wp_m;
    c_next.tog_m = ev_toggle;
    c_next.tog_s = c_reg.tog_m;
    c_next.tog_d = c_reg.tog_s;
    c_next.mem_we = 1'b0;
    start_cond = bus_cond(c_reg.scl_s, c_reg.scl_d, c_reg.sda_d, c_reg.sda_s) && !c_reg.sda_s;
    stop_cond = bus_cond(c_reg.scl_s, c_reg.scl_d, c_reg.sda_d, c_reg.sda_s) && c_reg.sda_s;
    ev_new = c_reg.tog_s ^ c_reg.tog_d;
    loc = c_reg.base[3:0] + c_reg.idx[3:0];
    // Bus free from a stop until SCL is seen low again
    if (stop_cond) begin
      c_next.bus_free = 1'b1;
    end else if (!c_reg.scl_s) begin
      c_next.bus_free = 1'b0;
    end
    unique case (c_reg.state)
      seew_pkg::CR_IDLE: begin
        if (ev_new && (ev_kind == seew_pkg::EV_DEVICE)) begin
          c_next.block = IS_16K ? ev_data[seew_pkg::BLOCK_HI:seew_pkg::BLOCK_LO]
                                : {1'b0, ev_data[seew_pkg::SMALL_BLOCK_HI:seew_pkg::BLOCK_LO]};
          c_next.valid = '0;
          c_next.state = seew_pkg::CR_COLLECT;
        end
      end
      seew_pkg::CR_COLLECT: begin
        if (stop_cond) begin
          if ((c_reg.valid != '0) && !c_reg.wp_s) begin
            c_next.state = seew_pkg::CR_PROGRAM;
            c_next.idx = '0;
            c_next.busy = 1'b1;
          end else begin
            c_next.state = seew_pkg::CR_IDLE;
          end
        end else if (start_cond) begin
          c_next.state = seew_pkg::CR_IDLE;
        end else if (ev_new) begin
          unique case (ev_kind)
            seew_pkg::EV_WORD: begin
              c_next.base = ev_data;
              c_next.ptr = ev_data[3:0];
            end
            seew_pkg::EV_DATA: begin
              c_next.page_buf[c_reg.ptr] = ev_data;
              c_next.valid[c_reg.ptr] = 1'b1;
              c_next.ptr = c_reg.ptr + 4'h1;
            end
            default: begin
              c_next.valid = '0;
            end
          endcase
        end
      end
      seew_pkg::CR_PROGRAM: begin
        if (c_reg.valid[loc]) begin
          c_next.mem_we = 1'b1;
          c_next.mem_addr = {c_reg.block, c_reg.base[7:4], loc};
          c_next.mem_data = c_reg.page_buf[loc];
        end
        c_next.idx = c_reg.idx + 5'h01;
        if (c_reg.idx == seew_pkg::PAGE_LAST) begin
          c_next.state = seew_pkg::CR_BUSY;
          c_next.cnt = '0;
        end
      end
      seew_pkg::CR_BUSY: begin
        c_next.cnt = c_reg.cnt + 20'h00001;
        if (c_reg.cnt == seew_pkg::BUSY_CNT_W'(WRITE_CYCLES - 1)) begin
          c_next.busy = 1'b0;
          c_next.state = seew_pkg::CR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      c_reg <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
                 state: seew_pkg::CR_IDLE, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = link_oe;
  assign BUSY_O = c_reg.busy;
  assign MEM_WE_O = c_reg.mem_we;
  assign MEM_ADDR_O = c_reg.mem_addr;
  assign MEM_DATA_O = c_reg.mem_data;
endmodule : seew_top

// File: logic/seew_link.sv
/*
  Shared constants of the two-wire EEPROM write slave, and the link-side
  bit framer that runs on the bus clock SCL. Assumes SCL and SDA come
  straight from the pins. Assumes SCL stands high while the bus is idle.
*/
// Functional notes
// - Start condition opens every transaction
// - Stop during read returns to standby
// - Stop during write starts programming
// - SDA change with SCL high is condition
// - Eight-bit bytes, ninth clock acknowledges
// - Busy device ignores bus, never acknowledges
// - Type code match, three block bits
// - Small variant: top block bit matches strap
// - Byte write: address, word, data, stop
// - Page write buffers up to sixteen bytes
// - Only low four address bits increment
// - Over sixteen bytes wrap and overwrite
// - Stop programs page from sent address
// - Write-protect input, high protects
// - Sample on rising, drive on falling
// - SDA driven only as open-drain pull-down
// - Protected device alters no location

package seew_pkg;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int STRAP_POS = 3;
  localparam int BLOCK_HI = 3;
  localparam int BLOCK_LO = 1;
  localparam int SMALL_BLOCK_HI = 2;
  localparam int RW_POS = 0;
  localparam int PAGE_BYTES = 16;
  localparam logic [4:0] PAGE_LAST = 5'h0F;
  localparam int BUSY_CNT_W = 20;
  localparam int WRITE_TIME_US = 1000;
  localparam int CORE_CLK_KHZ = 25000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CORE_CLK_KHZ / 1000;
  localparam logic [1:0] EV_DEVICE = 2'h0;
  localparam logic [1:0] EV_WORD = 2'h1;
  localparam logic [1:0] EV_DATA = 2'h2;

  typedef enum logic [3:0] {
    LK_IDLE = 4'b0001,
    LK_DEV = 4'b0010,
    LK_WORD = 4'b0100,
    LK_DATA = 4'b1000
  } seew_link_e;

  typedef enum logic [3:0] {
    CR_IDLE = 4'b0001,
    CR_COLLECT = 4'b0010,
    CR_PROGRAM = 4'b0100,
    CR_BUSY = 4'b1000
  } seew_core_e;
endpackage : seew_pkg

`timescale 1ns/1ps

module seew_link #(
  parameter logic [3:0] DEVICE_TYPE_CODE = 4'h5,
  parameter bit IS_16K = 1'b0
) (
  input wire logic scl_clk_i,
  input wire logic reset_n_i,
  input wire logic sda_i,
  input wire logic strap_i,
  input wire logic busy_i,
  input wire logic bus_free_i,
  output logic sda_oe_o,
  output logic ev_toggle_o,
  output logic [1:0] ev_kind_o,
  output logic [7:0] ev_data_o
);
  typedef struct packed {
    seew_pkg::seew_link_e state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic sda_rise;
    logic ack_want;
    logic ev_toggle;
    logic [1:0] ev_kind;
    logic [7:0] ev_data;
    logic busy_m;
    logic busy_s;
    logic strap_m;
    logic strap_s;
  } seew_rise_s;

  typedef struct packed {
    logic start_seen;
    logic oe;
  } seew_fall_s;

  seew_rise_s r_reg;
  seew_rise_s r_next;
  seew_fall_s f_reg;
  seew_fall_s f_next;
  logic [7:0] byte_v;
  logic match;

  always_comb begin
    r_next = r_reg;
    r_next.busy_m = busy_i;
    r_next.busy_s = r_reg.busy_m;
    r_next.strap_m = strap_i;
    r_next.strap_s = r_reg.strap_m;
    r_next.sda_rise = sda_i;
    byte_v = {r_reg.shreg[6:0], sda_i};
    match = (byte_v[seew_pkg::TYPE_HI:seew_pkg::TYPE_LO] == DEVICE_TYPE_CODE)
      && (IS_16K || (byte_v[seew_pkg::STRAP_POS] == r_reg.strap_s))
      && !r_reg.busy_s;
    if (f_reg.start_seen) begin
      r_next.state = seew_pkg::LK_DEV;
      r_next.shreg = byte_v;
      r_next.bitcnt = 4'h1;
      r_next.ack_want = 1'b0;
    end else if (r_reg.bitcnt == seew_pkg::BIT_ACK) begin
      r_next.bitcnt = 4'h0;
      r_next.ack_want = 1'b0;
    end else if (r_reg.state != seew_pkg::LK_IDLE) begin
      r_next.shreg = byte_v;
      r_next.bitcnt = r_reg.bitcnt + 4'h1;
      if (r_reg.bitcnt == seew_pkg::BIT_LAST) begin
        unique case (r_reg.state)
          seew_pkg::LK_IDLE: begin
          end
          seew_pkg::LK_DEV: begin
            r_next.ack_want = match;
            if (match && !byte_v[seew_pkg::RW_POS]) begin
              r_next.state = seew_pkg::LK_WORD;
              r_next.ev_toggle = ~r_reg.ev_toggle;
              r_next.ev_kind = seew_pkg::EV_DEVICE;
              r_next.ev_data = byte_v;
            end else begin
              // Read or mismatch: idle until the next start; a matching read still gets its address ack
              r_next.state = seew_pkg::LK_IDLE;
            end
          end
          seew_pkg::LK_WORD: begin
            r_next.ack_want = 1'b1;
            r_next.state = seew_pkg::LK_DATA;
            r_next.ev_toggle = ~r_reg.ev_toggle;
            r_next.ev_kind = seew_pkg::EV_WORD;
            r_next.ev_data = byte_v;
          end
          seew_pkg::LK_DATA: begin
            r_next.ack_want = 1'b1;
            r_next.ev_toggle = ~r_reg.ev_toggle;
            r_next.ev_kind = seew_pkg::EV_DATA;
            r_next.ev_data = byte_v;
          end
        endcase
      end
    end
  end

  always_comb begin
    // After a stop SCL stays high, so the last rise saw SDA low: the core's bus-free flag
    // stands for many core cycles around the start's SCL fall and stands in for that rise
    f_next.start_seen = (r_reg.sda_rise | bus_free_i) & ~sda_i;
    f_next.oe = r_reg.ack_want && (r_reg.bitcnt == seew_pkg::BIT_ACK);
  end

  always_ff @(posedge scl_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= '{state: seew_pkg::LK_IDLE, sda_rise: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(negedge scl_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  assign sda_oe_o = f_reg.oe;
  assign ev_toggle_o = r_reg.ev_toggle;
  assign ev_kind_o = r_reg.ev_kind;
  assign ev_data_o = r_reg.ev_data;
endmodule : seew_link

// File: verification/seew_top_props.sv
/*
  Port checker of seew_top, bound to every instance.
  Assumes SCL at exactly a quarter of the core clock.
*/
`timescale 1ns/1ps

module seew_top_props #(
  parameter int unsigned WRITE_CYCLES = 25000
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic WP_I,
  input wire logic ADDRESS_STRAP_PIN_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic BUSY_O,
  input wire logic MEM_WE_O,
  input wire logic [10:0] MEM_ADDR_O,
  input wire logic [7:0] MEM_DATA_O
);
  int unsigned busy_cnt;
  int unsigned wp_cnt;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      busy_cnt <= 0;
      wp_cnt <= 0;
    end else begin
      busy_cnt <= BUSY_O ? busy_cnt + 1 : 0;
      wp_cnt <= WP_I ? wp_cnt + 1 : 0;
    end
  end
  sequence ack_hold;
    SDA_OE_O [*4] ##1 !SDA_OE_O;
  endsequence
  sequence we_pair;
    MEM_WE_O ##1 MEM_WE_O;
  endsequence
  a_pull_down_only: assert property (SDA_O == 1'b0)
    else $error("SDA data not low");
  a_oe_scl_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("SDA enable moved with SCL high");
  a_ack_whole_clock: assert property ($rose(SDA_OE_O) |-> ack_hold)
    else $error("Ack too short");
  a_busy_no_ack: assert property (busy_cnt > 40 |-> !SDA_OE_O)
    else $error("Ack while busy");
  a_we_in_scan: assert property (MEM_WE_O |-> BUSY_O && busy_cnt <= 18)
    else $error("Write outside scan");
  a_page_fixed: assert property (we_pair |-> MEM_ADDR_O[10:4] == $past(MEM_ADDR_O[10:4])
    && MEM_ADDR_O[3:0] == $past(MEM_ADDR_O[3:0]) + 4'h1) else $error("Page address moved");
  a_busy_length: assert property ($fell(BUSY_O) |-> busy_cnt >= WRITE_CYCLES + 15
    && busy_cnt <= WRITE_CYCLES + 18) else $error("Busy length wrong");
  a_protect_quiet: assert property (wp_cnt > 4 |-> !$rose(BUSY_O))
    else $error("Busy while protected");
endmodule : seew_top_props

bind seew_top seew_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_seew_top_props (.CORE_CLK_I, .RESET_N_I,
  .SCL_I, .SDA_I, .WP_I, .ADDRESS_STRAP_PIN_I, .SDA_O, .SDA_OE_O, .BUSY_O, .MEM_WE_O, .MEM_ADDR_O, .MEM_DATA_O);

// File: verification/seew_master.sv
/*
  Bus master model driving SCL and an open-drain SDA pull-down.
  Assumes the bench resolves the SDA wire onto sda_i.
*/
`timescale 1ns/1ps

module seew_master (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  localparam int Q = 40;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start_cond();
    #Q;
    sda_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #(2 * Q);
    sda_o = 1'b0;
    #(2 * Q);
    scl_o = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #Q;
    sda_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #(2 * Q);
    sda_o = 1'b1;
    #(2 * Q);
  endtask : stop_cond
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      #Q;
      sda_o = (i == 0) ? 1'b1 : b[i - 1];
      #Q;
      scl_o = 1'b1;
      #Q;
      ack = !sda_i;
      #Q;
      scl_o = 1'b0;
    end
  endtask : put_byte
endmodule : seew_master

// File: verification/seew_top_tb_top.sv
/*
  Testbench of seew_top: master model writes, a queue predicts writes.
  Assumes the 8k variant with its strap.
*/
`timescale 1ns/1ps

module seew_top_tb_top;
  localparam logic [3:0] CODE = 4'h5; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic strap = 1'b0;
  logic m_scl;
  logic m_sda;
  logic sda_o;
  logic sda_oe;
  logic busy;
  logic we;
  logic [10:0] addr;
  logic [7:0] data;
  wire sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
  int checked = 0;
  int miscompares = 0;
  int seed;
  logic [18:0] exp_q[$];
  int lens[7] = '{1, 16, 20, 3, 0, 2, 2};
  always #20 clk = ~clk;
  seew_top #(.DEVICE_TYPE_CODE(CODE), .WRITE_CYCLES(200)) i_seew_top (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .SCL_I(m_scl), .SDA_I(sda_w), .WP_I(wp), .ADDRESS_STRAP_PIN_I(strap), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .BUSY_O(busy), .MEM_WE_O(we), .MEM_ADDR_O(addr), .MEM_DATA_O(data));
  seew_master i_seew_master (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda_w));
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic wr(input int n, input bit bad_code, input bit bad_strap);
    logic [7:0] dev;
    logic [7:0] w;
    logic [7:0] d;
    logic [7:0] slot[16];
    bit v[16];
    logic a;
    bit ok;
    int polls;
    w = 8'($random(seed));
    dev = {bad_code ? CODE ^ 4'h3 : CODE, strap ^ bad_strap, 2'($random(seed)), 1'b0};
    ok = !bad_code && !bad_strap;
    i_seew_master.start_cond();
    i_seew_master.put_byte(dev, a);
    check("address ack", a, ok);
    i_seew_master.put_byte(w, a);
    check("word ack", a, ok);
    for (int i = 0; i < n && ok; i++) begin
      d = 8'($random(seed));
      slot[(w + i) % 16] = d;
      v[(w + i) % 16] = 1'b1;
      i_seew_master.put_byte(d, a);
      check("data ack", a, 1'b1);
    end
    for (int k = 0; k < 16; k++) begin
      if (v[(w + k) % 16] && !wp) exp_q.push_back({1'b0, dev[2:1], w[7:4], 4'((w + k) % 16), slot[(w + k) % 16]});
    end
    i_seew_master.stop_cond();
    if (ok && n > 0 && !wp) begin
      repeat (2) @(posedge clk);
      #2;
      check("busy after stop", busy, 1'b1);
      polls = 0;
      a = 1'b0;
      while (!a && polls < 20) begin
        i_seew_master.start_cond();
        i_seew_master.put_byte({dev[7:1], 1'b1}, a);
        i_seew_master.stop_cond();
        polls++;
      end
      check("busy polls", polls > 1 && a, 1'b1);
    end else begin
      repeat (10) @(posedge clk);
      #2;
      check("busy stays low", busy, 1'b0);
    end
    check("writes left", exp_q.size(), 0);
  endtask : wr
  always @(negedge clk) begin
    if (we === 1'b1) check("memory write", {addr, data}, exp_q.size() ? exp_q.pop_front() : 19'h7FFFF);
  end
  initial begin
    seed = 32'hD1C987D1;
    repeat (10) @(posedge clk);
    #2;
    check("reset outputs", {sda_o, sda_oe, busy, we, addr, data}, 0);
    rst_n = 1'b1;
    for (int k = 0; k < 7; k++) begin
      repeat (4) @(posedge clk);
      #2;
      wp = (k == 3);
      strap = 1'($random(seed));
      wr(lens[k], k == 5, k == 6);
    end
    wrap_up();
  end
  initial begin
    #1000000;
    miscompares++;
    wrap_up();
  end
endmodule : seew_top_tb_top
